// [logic/sdi_regs.svh]
// Mode register addresses, reset defaults, command codes and output timing
`ifndef SDI_REGS_SVH
`define SDI_REGS_SVH
`define SDI_MR1            6'h01
`define SDI_MR2            6'h02
`define SDI_MR3            6'h03
`define SDI_MR11           6'h0b
`define SDI_MR12           6'h0c
`define SDI_MR13           6'h0d
`define SDI_MR14           6'h0e
`define SDI_FSP_RST        2'h0
`define SDI_WLS_RST        1'h0
`define SDI_WL_RST         3'h0
`define SDI_RL_RST         3'h0
`define SDI_NWR_RST        3'h0
`define SDI_DBI_RST        2'h0
`define SDI_ODT_RST        3'h0
`define SDI_VREF_RNG_RST   1'h1
`define SDI_VREF_VAL_RST   6'h1d
`define SDI_WRLEV_BIT      7
`define SDI_CBT_BIT        0
`define SDI_NWR_F          6:4
`define SDI_DBI_F          7:6
`define SDI_CAODT_F        6:4
`define SDI_DQODT_F        2:0
`define SDI_VR_F           6:0
`define SDI_FSP_F          7:6
`define SDI_MPC_ZQ_START   8'h4f
`define SDI_MPC_ZQ_LATCH   8'h51
`define SDI_MPC_RDCAL      8'h43
`define SDI_MPC_FIFO_WR    8'h47
`define SDI_MPC_FIFO_RD    8'h41
`define SDI_RDCAL_PAT      8'h5a
`define SDI_DQ_HOLD        4'h8
`endif

// [logic/sdi_pkg.sv]
// Types shared by the power-up initialization sequencer
package sdi_pkg;
  typedef enum logic [1:0] {
    SDI_CMD_NOP = 2'b00,
    SDI_CMD_MRW = 2'b01,
    SDI_CMD_MRR = 2'b10,
    SDI_CMD_MPC = 2'b11
  } sdi_cmd_t;

  typedef struct packed {
    logic       cs;
    sdi_cmd_t   cmd;
    logic [5:0] addr;
    logic [7:0] data;
  } sdi_ca_t;

  typedef struct packed {
    logic [1:0] freq_set_point_select;
    logic       write_latency_set;
    logic [2:0] write_latency;
    logic [2:0] read_latency;
    logic [2:0] write_recovery;
    logic [1:0] bus_inversion_enables;
    logic [2:0] ca_on_die_termination;
    logic [2:0] dq_on_die_termination;
    logic       command_bus_reference_rng;
    logic [5:0] command_bus_reference;
    logic       dq_bus_reference_rng;
    logic [5:0] dq_bus_reference;
    logic       wrlev;
    logic       cbt;
  } sdi_mode_t;

  typedef enum logic [3:0] {
    ST_RESET     = 4'b0000,
    ST_BOOT      = 4'b0001,
    ST_ZQ_RUN    = 4'b0010,
    ST_ZQ_DONE   = 4'b0011,
    ST_CBT       = 4'b0100,
    ST_WRLEV_WT  = 4'b0101,
    ST_WRLEV     = 4'b0110,
    ST_DQTRAIN   = 4'b0111,
    ST_READY     = 4'b1000
  } sdi_state_t;
endpackage : sdi_pkg

// [logic/sdi_init_top.sv]
// Device-side power-up and reset initialization sequencer
`timescale 1ns/1ps
`include "sdi_regs.svh"
module sdi_init_top
  import sdi_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        diff_clock_true_i,
  input  wire logic        reset_pin_n_i,
  input  wire logic        cke_i,
  input  wire sdi_ca_t     ca_i,
  input  wire logic [7:0]  dq_pin_i,
  input  wire logic [7:0]  zq_code_i,
  output logic [7:0]       dq_o,
  output logic             dq_oe_o,
  output sdi_mode_t        mode_o,
  output logic [7:0]       drive_code_o,
  output logic             ready_o
);
  localparam sdi_mode_t MODE_RST = '{
    freq_set_point_select: `SDI_FSP_RST, write_latency_set: `SDI_WLS_RST,
    write_latency: `SDI_WL_RST, read_latency: `SDI_RL_RST,
    write_recovery: `SDI_NWR_RST, bus_inversion_enables: `SDI_DBI_RST,
    ca_on_die_termination: `SDI_ODT_RST, dq_on_die_termination: `SDI_ODT_RST,
    command_bus_reference_rng: `SDI_VREF_RNG_RST, command_bus_reference: `SDI_VREF_VAL_RST,
    dq_bus_reference_rng: `SDI_VREF_RNG_RST, dq_bus_reference: `SDI_VREF_VAL_RST,
    wrlev: 1'h0, cbt: 1'h0};

  // Link-side synchronisers
  logic       lrst_s1_q, lrst_s2_q, ack_l1_q, ack_l2_q;
  logic [7:0] zq_s1_q, zq_s2_q;
  logic       lrst;
  always_ff @(posedge diff_clock_true_i)
  begin
    lrst_s1_q <= ~reset_pin_n_i;
    lrst_s2_q <= lrst_s1_q;
    zq_s1_q   <= zq_code_i;
    zq_s2_q   <= zq_s1_q;
  end
  assign lrst = lrst_s2_q;

  // Link-side sequencer state
  sdi_state_t state_q, state_d;
  sdi_mode_t  mode_q, mode_d;
  logic [7:0] drive_q, drive_d, fifo_q, fifo_d, resp_q, resp_d;
  logic       req_q, req_d, ready_q, ready_d, ack_c_q;
  logic       take, busy, mode_register_write, multipurpose_command;

  function automatic logic [7:0] mr_read(input logic [5:0] a, input sdi_mode_t m);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      `SDI_MR1:  v = {1'b0, m.write_recovery, 4'h0};
      `SDI_MR2:  v = {m.wrlev, m.write_latency_set, m.write_latency, m.read_latency};
      `SDI_MR3:  v = {m.bus_inversion_enables, 6'h00};
      `SDI_MR11: v = {1'b0, m.ca_on_die_termination, 1'b0, m.dq_on_die_termination};
      `SDI_MR12: v = {1'b0, m.command_bus_reference_rng, m.command_bus_reference};
      `SDI_MR13: v = {m.freq_set_point_select, 5'h00, m.cbt};
      `SDI_MR14: v = {1'b0, m.dq_bus_reference_rng, m.dq_bus_reference};
      default:   v = 8'h00;
    endcase
    return v;
  endfunction : mr_read

  assign take = cke_i && ca_i.cs && (ca_i.cmd != SDI_CMD_NOP);
  assign busy = req_q != ack_l2_q;
  assign mode_register_write  = take && (ca_i.cmd == SDI_CMD_MRW);
  assign multipurpose_command  = take && (ca_i.cmd == SDI_CMD_MPC);

  always_comb
  begin
    state_d = state_q;
    mode_d  = mode_q;
    drive_d = drive_q;
    fifo_d  = fifo_q;
    resp_d  = resp_q;
    req_d   = req_q;
    if (mode_register_write && state_q != ST_RESET)
    begin
      case (ca_i.addr)
        `SDI_MR1:  mode_d.write_recovery = ca_i.data[`SDI_NWR_F];
        `SDI_MR2:  {mode_d.wrlev, mode_d.write_latency_set, mode_d.write_latency,
                    mode_d.read_latency} = ca_i.data;
        `SDI_MR3:  mode_d.bus_inversion_enables = ca_i.data[`SDI_DBI_F];
        `SDI_MR11: {mode_d.ca_on_die_termination, mode_d.dq_on_die_termination} =
                   {ca_i.data[`SDI_CAODT_F], ca_i.data[`SDI_DQODT_F]};
        `SDI_MR12: {mode_d.command_bus_reference_rng, mode_d.command_bus_reference} =
                   ca_i.data[`SDI_VR_F];
        `SDI_MR13: {mode_d.freq_set_point_select, mode_d.cbt} =
                   {ca_i.data[`SDI_FSP_F], ca_i.data[`SDI_CBT_BIT]};
        `SDI_MR14: {mode_d.dq_bus_reference_rng, mode_d.dq_bus_reference} = ca_i.data[`SDI_VR_F];
        default:   mode_d = mode_q;
      endcase
    end
    // Responses go out only when the previous word has been taken over
    if (take && !busy && state_q != ST_RESET)
    begin
      if (state_q == ST_CBT)
      begin
        resp_d = {ca_i.cmd, ca_i.addr};
        req_d  = ~req_q;
      end
      else if (ca_i.cmd == SDI_CMD_MRR)
      begin
        resp_d = mr_read(ca_i.addr, mode_q);
        req_d  = ~req_q;
      end
      else if (multipurpose_command && ca_i.data == `SDI_MPC_RDCAL)
      begin
        resp_d = `SDI_RDCAL_PAT;
        req_d  = ~req_q;
      end
      else if (multipurpose_command && ca_i.data == `SDI_MPC_FIFO_RD)
      begin
        resp_d = fifo_q;
        req_d  = ~req_q;
      end
    end
    if (multipurpose_command && ca_i.data == `SDI_MPC_FIFO_WR && state_q != ST_RESET)
      fifo_d = dq_pin_i;
    case (state_q)
      ST_RESET:    if (cke_i) state_d = ST_BOOT;
      ST_BOOT:     if (multipurpose_command && ca_i.data == `SDI_MPC_ZQ_START) state_d = ST_ZQ_RUN;
      ST_ZQ_RUN:
      begin
        if (multipurpose_command && ca_i.data == `SDI_MPC_ZQ_LATCH)
        begin
          drive_d = zq_s2_q;
          state_d = ST_ZQ_DONE;
        end
      end
      ST_ZQ_DONE:  if (mode_register_write && ca_i.addr == `SDI_MR13 && ca_i.data[`SDI_CBT_BIT])
                     state_d = ST_CBT;
      ST_CBT:      if (mode_register_write && ca_i.addr == `SDI_MR13 && !ca_i.data[`SDI_CBT_BIT])
                     state_d = ST_WRLEV_WT;
      ST_WRLEV_WT: if (mode_register_write && ca_i.addr == `SDI_MR2 && ca_i.data[`SDI_WRLEV_BIT])
                     state_d = ST_WRLEV;
      ST_WRLEV:    if (mode_register_write && ca_i.addr == `SDI_MR2 && !ca_i.data[`SDI_WRLEV_BIT])
                     state_d = ST_DQTRAIN;
      ST_DQTRAIN:  if (mode_register_write && ca_i.addr != `SDI_MR14) state_d = ST_READY;
      ST_READY:    state_d = ST_READY;
      default:     state_d = ST_RESET;
    endcase
    ready_d = state_d == ST_READY;
  end

  always_ff @(posedge diff_clock_true_i)
  begin
    if (lrst)
    begin
      state_q <= ST_RESET;
      mode_q  <= MODE_RST;
      drive_q <= 8'h00;
      fifo_q  <= 8'h00;
      resp_q  <= 8'h00;
      req_q   <= 1'b0;
      ready_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      mode_q  <= mode_d;
      drive_q <= drive_d;
      fifo_q  <= fifo_d;
      resp_q  <= resp_d;
      req_q   <= req_d;
      ready_q <= ready_d;
    end
    ack_l1_q <= ack_c_q;
    ack_l2_q <= ack_l1_q;
  end

  assign mode_o       = mode_q;
  assign drive_code_o = drive_q;
  assign ready_o      = ready_q;

  // System-side data output with handshake back to the link side
  logic       crst_s1_q, crst_s2_q, req_s1_q, req_s2_q, req_s3_q;
  logic       oe_q, oe_d, ack_c_d;
  logic [7:0] dq_q, dq_d;
  logic [3:0] hold_q, hold_d;
  logic       crst;
  assign crst = sys_rst_i || crst_s2_q;

  always_comb
  begin
    dq_d    = dq_q;
    oe_d    = oe_q;
    ack_c_d = ack_c_q;
    hold_d  = hold_q;
    if (req_s2_q != req_s3_q)
    begin
      dq_d    = resp_q;
      oe_d    = 1'b1;
      ack_c_d = req_s2_q;
      hold_d  = `SDI_DQ_HOLD;
    end
    else if (hold_q != 4'h0)
      hold_d = hold_q - 4'h1;
    else
      oe_d = 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    crst_s1_q <= ~reset_pin_n_i;
    crst_s2_q <= crst_s1_q;
    req_s1_q  <= req_q;
    req_s2_q  <= req_s1_q;
    if (crst)
    begin
      req_s3_q <= 1'b0;
      dq_q     <= 8'h00;
      oe_q     <= 1'b0;
      ack_c_q  <= 1'b0;
      hold_q   <= 4'h0;
    end
    else
    begin
      req_s3_q <= req_s2_q;
      dq_q     <= dq_d;
      oe_q     <= oe_d;
      ack_c_q  <= ack_c_d;
      hold_q   <= hold_d;
    end
  end

  assign dq_o    = dq_q;
  assign dq_oe_o = oe_q;

  // Checks
  a_mode_lat_dflt: assert property (@(posedge diff_clock_true_i) $fell(lrst) |->
    mode_q.freq_set_point_select == `SDI_FSP_RST && mode_q.write_latency == `SDI_WL_RST &&
    mode_q.read_latency == `SDI_RL_RST && mode_q.write_recovery == `SDI_NWR_RST)
    else $error("latency defaults wrong after reset");
  a_mode_term_dflt: assert property (@(posedge diff_clock_true_i) $fell(lrst) |->
    mode_q.bus_inversion_enables == `SDI_DBI_RST &&
    mode_q.ca_on_die_termination == `SDI_ODT_RST && mode_q.dq_on_die_termination == `SDI_ODT_RST)
    else $error("termination defaults wrong after reset");
  a_mode_vref_dflt: assert property (@(posedge diff_clock_true_i) $fell(lrst) |->
    mode_q.command_bus_reference == 6'h1d && mode_q.dq_bus_reference == 6'h1d &&
    mode_q.command_bus_reference_rng && mode_q.dq_bus_reference_rng)
    else $error("reference defaults wrong after reset");
  a_dq_hiz_reset: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    crst_s2_q |=> !dq_oe_o)
    else $error("data driven during reset");
  a_zq_latch_apply: assert property (@(posedge diff_clock_true_i) disable iff (lrst)
    (state_q == ST_ZQ_RUN && multipurpose_command && ca_i.data == `SDI_MPC_ZQ_LATCH) |=>
    drive_code_o == $past(zq_s2_q) && state_q == ST_ZQ_DONE)
    else $error("calibration code not applied on latch");
  a_cbt_echo: assert property (@(posedge diff_clock_true_i) disable iff (lrst)
    (state_q == ST_CBT && take && !busy) |=>
    resp_q == $past({ca_i.cmd, ca_i.addr}) && req_q != $past(req_q))
    else $error("training pattern not returned");
  a_wrlev_entry: assert property (@(posedge diff_clock_true_i) disable iff (lrst)
    (state_q == ST_WRLEV_WT && mode_register_write && ca_i.addr == `SDI_MR2 && ca_i.data[`SDI_WRLEV_BIT]) |=>
    state_q == ST_WRLEV && mode_o.wrlev)
    else $error("write leveling not entered");
  a_mpc_no_mode: assert property (@(posedge diff_clock_true_i) disable iff (lrst)
    multipurpose_command |=> $stable(mode_q))
    else $error("training command changed settings");
  a_ready_after: assert property (@(posedge diff_clock_true_i) disable iff (lrst)
    (state_q == ST_DQTRAIN && mode_register_write && ca_i.addr != `SDI_MR14) |=> ready_o ##1 ready_o)
    else $error("not ready after training");
  a_reset_any: assert property (@(posedge diff_clock_true_i) $fell(lrst) |->
    state_q == ST_RESET && !ready_o)
    else $error("reset state not entered");
  c_ready: cover property (@(posedge diff_clock_true_i) disable iff (lrst) $rose(ready_o));
  c_cbt_resp: cover property (@(posedge clk_i) disable iff (crst) $rose(dq_oe_o) && dq_q != 8'h00);
  c_zq_latch: cover property (@(posedge diff_clock_true_i) disable iff (lrst)
    state_q == ST_ZQ_RUN ##1 state_q == ST_ZQ_DONE);
endmodule : sdi_init_top

// [tb/sdi_ctrl_model.sv]
// Controller model driving reset pin, clock enable and command bus
`timescale 1ns/1ps
module sdi_ctrl_model
  import sdi_pkg::*;
#(
  parameter int RST_CYC  = 3,
  parameter int CKE_CYC  = 6,
  parameter int IDLE_CYC = 25,
  parameter int GAP_CYC  = 16
)(
  input  wire logic lclk_i,
  output logic      reset_pin_n_o,
  output logic      cke_o,
  output sdi_ca_t   ca_o
);
  // One device on one channel, no shared calibration resistor
  initial
  begin
    reset_pin_n_o = 1'b0;
    cke_o         = 1'b0;
    ca_o          = '0;
  end

  // Drives on the falling link edge, the device samples on the rising one
  task automatic hold_rst();
    @(negedge lclk_i);
    cke_o         <= 1'b0;
    reset_pin_n_o <= 1'b0;
    repeat (RST_CYC) @(negedge lclk_i);
  endtask : hold_rst

  task automatic powerup();
    @(negedge lclk_i);
    reset_pin_n_o <= 1'b1;
    ca_o.cs       <= 1'b0;
    repeat (CKE_CYC) @(negedge lclk_i);
    cke_o <= 1'b1;
    repeat (IDLE_CYC) @(negedge lclk_i);
  endtask : powerup

  // Link clock period sits above the boot minimum
  task automatic cmd(input sdi_cmd_t c, input logic [5:0] a, input logic [7:0] d);
    @(negedge lclk_i);
    ca_o <= {1'b1, c, a, d};
    @(negedge lclk_i);
    ca_o <= {1'b0, ~c, ~a, ~d};
  endtask : cmd

  // Spacing rounded up to cover calibration and latch quiet time
  task automatic gap();
    repeat (GAP_CYC) @(negedge lclk_i);
  endtask : gap
endmodule : sdi_ctrl_model

// [tb/sdi_init_top_tb_top.sv]
// Testbench for the power-up initialization sequencer
`timescale 1ns/1ps
`include "sdi_regs.svh"
`define CHK(n, e, s) begin n_compared++; if ((e) !== (s)) begin n_fail++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module sdi_init_top_tb_top
  import sdi_pkg::*;
;
  typedef struct packed {
    sdi_cmd_t   c;
    logic [5:0] a;
    logic [7:0] d;
    logic       rsp;
    logic [7:0] q;
    logic       rdy;
  } sdi_row_t;

  logic       clk_i;
  logic       lclk;
  logic       sys_rst_i;
  logic       reset_pin_n;
  logic       cke;
  sdi_ca_t    ca;
  logic [7:0] dq_pin_i;
  logic [7:0] zq_code_i;
  logic [7:0] dq_o;
  logic       dq_oe_o;
  sdi_mode_t  mode_o;
  logic [7:0] drive_code_o;
  logic       ready_o;
  int         n_fail;
  int         n_compared;
  int         n_cyc;
  int         i;
  sdi_row_t   rows [19] = '{
    '{SDI_CMD_MPC, 6'h00, `SDI_MPC_ZQ_START, 1'b0, 8'h00, 1'b0},
    '{SDI_CMD_MPC, 6'h00, `SDI_MPC_ZQ_LATCH, 1'b0, 8'h00, 1'b0},
    '{SDI_CMD_MRW, `SDI_MR13, 8'h01, 1'b0, 8'h00, 1'b0},
    '{SDI_CMD_MRW, `SDI_MR12, 8'h2a, 1'b1, 8'h4c, 1'b0},
    '{SDI_CMD_MRW, `SDI_MR13, 8'h00, 1'b1, 8'h4d, 1'b0},
    '{SDI_CMD_MRW, `SDI_MR2, 8'h80, 1'b0, 8'h00, 1'b0},
    '{SDI_CMD_MRW, `SDI_MR2, 8'h00, 1'b0, 8'h00, 1'b0},
    '{SDI_CMD_MPC, 6'h00, `SDI_MPC_RDCAL, 1'b1, `SDI_RDCAL_PAT, 1'b0},
    '{SDI_CMD_MPC, 6'h00, `SDI_MPC_FIFO_WR, 1'b0, 8'h00, 1'b0},
    '{SDI_CMD_MPC, 6'h00, `SDI_MPC_FIFO_RD, 1'b1, 8'ha5, 1'b0},
    '{SDI_CMD_MRW, `SDI_MR1, 8'h60, 1'b0, 8'h00, 1'b1},
    '{SDI_CMD_MRW, `SDI_MR3, 8'hc0, 1'b0, 8'h00, 1'b1},
    '{SDI_CMD_MRW, `SDI_MR11, 8'h35, 1'b0, 8'h00, 1'b1},
    '{SDI_CMD_MRW, `SDI_MR14, 8'h12, 1'b0, 8'h00, 1'b1},
    '{SDI_CMD_MRW, `SDI_MR13, 8'hc0, 1'b0, 8'h00, 1'b1},
    '{SDI_CMD_MRR, `SDI_MR3, 8'h00, 1'b1, 8'hc0, 1'b1},
    '{SDI_CMD_MRR, `SDI_MR11, 8'h00, 1'b1, 8'h35, 1'b1},
    '{SDI_CMD_MRR, `SDI_MR14, 8'h00, 1'b1, 8'h12, 1'b1},
    '{SDI_CMD_MRR, `SDI_MR13, 8'h00, 1'b1, 8'hc0, 1'b1}
  };

  sdi_init_top DUT (
    .clk_i             (clk_i),
    .sys_rst_i         (sys_rst_i),
    .diff_clock_true_i (lclk),
    .reset_pin_n_i     (reset_pin_n),
    .cke_i             (cke),
    .ca_i              (ca),
    .dq_pin_i          (dq_pin_i),
    .zq_code_i         (zq_code_i),
    .dq_o              (dq_o),
    .dq_oe_o           (dq_oe_o),
    .mode_o            (mode_o),
    .drive_code_o      (drive_code_o),
    .ready_o           (ready_o)
  );

  sdi_ctrl_model u_ctrl (
    .lclk_i        (lclk),
    .reset_pin_n_o (reset_pin_n),
    .cke_o         (cke),
    .ca_o          (ca)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  initial
  begin
    lclk = 1'b0;
    #7;
    forever #40 lclk = ~lclk;
  end

  task automatic test_done();
    if (n_fail == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done

  always @(posedge clk_i)
  begin
    n_cyc++;
    if (n_cyc == 6000)
    begin
      n_fail++;
      test_done();
    end
  end

  task automatic chk_dflt();
    `CHK("fsp", 2'h0, mode_o.freq_set_point_select)
    `CHK("lat", 10'h000, {mode_o.write_latency_set, mode_o.write_latency,
      mode_o.read_latency, mode_o.write_recovery})
    `CHK("dbi", 2'h0, mode_o.bus_inversion_enables)
    `CHK("odt", 6'h00, {mode_o.ca_on_die_termination, mode_o.dq_on_die_termination})
    `CHK("vca", 7'h5d, {mode_o.command_bus_reference_rng, mode_o.command_bus_reference})
    `CHK("vdq", 7'h5d, {mode_o.dq_bus_reference_rng, mode_o.dq_bus_reference})
  endtask : chk_dflt

  task automatic wait_dq(input logic [7:0] q);
    int k;
    for (k = 0; k < 40 && dq_oe_o !== 1'b1; k++) @(negedge clk_i);
    `CHK("dq_oe", 1'b1, dq_oe_o)
    `CHK("dq", q, dq_o)
  endtask : wait_dq

  initial
  begin
    n_fail = 0;
    n_compared = 0;
    n_cyc = 0;
    sys_rst_i = 1'b1;
    zq_code_i = 8'h3c;
    dq_pin_i = 8'ha5;
    repeat (6) @(negedge clk_i);
    sys_rst_i = 1'b0;
    repeat (8) @(negedge clk_i);
    chk_dflt();
    `CHK("dq_oe", 1'b0, dq_oe_o)
    u_ctrl.powerup();
    for (i = 0; i < 19; i++)
    begin
      u_ctrl.cmd(rows[i].c, rows[i].a, rows[i].d);
      if (rows[i].rsp)
        wait_dq(rows[i].q);
      u_ctrl.gap();
      @(negedge clk_i);
      `CHK("ready", rows[i].rdy, ready_o)
    end
    zq_code_i = 8'hc3;
    repeat (8) @(negedge clk_i);
    `CHK("drive", 8'h3c, drive_code_o)
    `CHK("vca_w", 7'h2a, {mode_o.command_bus_reference_rng, mode_o.command_bus_reference})
    `CHK("nwr", 3'h6, mode_o.write_recovery)
    u_ctrl.cmd(SDI_CMD_MRR, `SDI_MR1, 8'h00);
    wait_dq(8'h60);
    u_ctrl.hold_rst();
    @(negedge clk_i);
    `CHK("dq_oe", 1'b0, dq_oe_o)
    `CHK("ready", 1'b0, ready_o)
    chk_dflt();
    u_ctrl.powerup();
    u_ctrl.cmd(SDI_CMD_MRR, `SDI_MR12, 8'h00);
    wait_dq(8'h5d);
    u_ctrl.gap();
    `CHK("ready", 1'b0, ready_o)
    test_done();
  end
endmodule : sdi_init_top_tb_top
